// ---- hw/sdc_pkg.sv ----
// package of constants and types for the segment display controller
package sdc_pkg;
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CFG  = 2'h1;
  localparam logic [1:0] ADDR_FRR  = 2'h2;
  localparam int BIT_EN    = 7;
  localparam int BIT_LP    = 6;
  localparam int BIT_FLAG  = 4;
  localparam int BIT_IE    = 3;
  localparam int BIT_BLANK = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int NUM_COM = 4;
  localparam int NUM_SEG = 40;
  localparam logic [2:0] K_THIRD = 3'h5;  // six steps, last index
  localparam logic [2:0] K_OTHER = 3'h7;  // eight steps, last index
  localparam logic [1:0] DUTY_STATIC = 2'h0;
  localparam logic [1:0] DUTY_THIRD  = 2'h2;
  localparam int PS_W = 12;
  // prescaler tap masks, division minus one
  localparam logic [11:0] TAP_MASK [8] = '{12'h00F, 12'h03F, 12'h07F, 12'h0FF,
                                           12'h1FF, 12'h3FF, 12'h7FF, 12'hFFF};
  // segment driver count per port mask code
  localparam logic [5:0] SEG_COUNT [16] = '{6'h0D, 6'h0F, 6'h11, 6'h13, 6'h15, 6'h17,
                                            6'h18, 6'h19, 6'h1B, 6'h1D, 6'h1F, 6'h21,
                                            6'h23, 6'h25, 6'h27, 6'h28};
  typedef enum logic [1:0] {BIAS_STATIC, BIAS_THIRD, BIAS_HALF} sdc_bias_type;
  typedef struct packed {
    logic       async_clock_select;
    logic       half_bias_select;
    logic [1:0] duty_select;
    logic [3:0] segment_port_mask;
  } sdc_cfg_type;
  typedef struct packed {
    logic       rsvd7;
    logic [2:0] prescaler_tap_select;
    logic       rsvd3;
    logic [2:0] frame_clock_divide;
  } sdc_frr_type;
endpackage

// ---- hw/sdc_prescaler.sv ----
// prescaler tap and clock divider producing the prescaled display tick
`timescale 1ns/1ps
module sdc_prescaler
  import sdc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       disp_tick,
  input  wire logic [2:0] tap_sel,
  input  wire logic [2:0] divide,
  output logic            ps_tick
);
  logic [PS_W-1:0] cnt_r;
  logic [2:0]      div_r;
  logic            tap_hit;

  // tap fires every N display clocks
  assign tap_hit = disp_tick && ((cnt_r & TAP_MASK[tap_sel]) == TAP_MASK[tap_sel]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else if (disp_tick) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  // further divide by field plus one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r   <= 3'h0;
      ps_tick <= 1'b0;
    end else begin
      ps_tick <= 1'b0;
      if (!run) begin
        div_r <= 3'h0;
      end else if (tap_hit) begin
        if (div_r >= divide) begin
          div_r   <= 3'h0;
          ps_tick <= 1'b1;
        end else begin
          div_r <= div_r + 3'h1;
        end
      end
    end
  end
endmodule

// ---- hw/sdc_seg_mask.sv ----
// terminal ownership: which commons and segments the controller drives
`timescale 1ns/1ps
module sdc_seg_mask
  import sdc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               enable,
  input  wire logic [1:0]         duty,
  input  wire logic [3:0]         mask_code,
  output logic [NUM_COM-1:0]      com_own,
  output logic [NUM_SEG-1:0]      seg_own
);
  logic [5:0] seg_cnt;
  assign seg_cnt = SEG_COUNT[mask_code];

  genvar i;
  generate
    for (i = 0; i < NUM_SEG; i = i + 1) begin : g_seg
      // segments below the mask count are display drivers
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          seg_own[i] <= 1'b0;
        end else begin
          seg_own[i] <= enable && (6'(i) < seg_cnt);
        end
      end
    end
    for (i = 0; i < NUM_COM; i = i + 1) begin : g_com
      // commons up to the duty index are driven
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          com_own[i] <= 1'b0;
        end else begin
          com_own[i] <= enable && (2'(i) <= duty);
        end
      end
    end
  endgenerate
endmodule

// ---- hw/sdc_ctrl.sv ----
// segment display controller: registers, clock select, frame sequencer
`timescale 1ns/1ps
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
)(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  input  wire logic               global_irq_enable,
  input  wire logic               irq_ack,
  input  wire logic               external_clock_input_enable,
  input  wire logic               timer_osc_input_pin,
  input  wire logic               ext_clock_pin,
  output logic                    frame_irq,
  output logic                    frame_latch,
  output logic                    frame_step_tick,
  output logic [2:0]              frame_step,
  output logic                    drive_ground,
  output logic                    low_power_active,
  output sdc_bias_type            bias_mode,
  output logic [NUM_COM-1:0]      com_drive_en,
  output logic [NUM_SEG-1:0]      seg_drive_en
);
  ////////////////////////////////////////////////////////////////////////
  logic        controller_enable_r;
  logic        low_power_waveform_sel_r;
  logic        frame_start_flag_r;
  logic        frame_start_irq_enable_r;
  logic        display_blank_r;
  sdc_cfg_type cfg_r;
  sdc_frr_type frr_r;
  logic        frame_end;
  logic        flag_set;
  logic        wr_ctrl;
  logic        lp_phase_r;
  logic        blank_act_r;
  logic        lp_act_r;
  logic [2:0]  step_r;
  logic [2:0]  k_last;
  logic        ps_tick;

  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);

  // enable bit written directly, stop is immediate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      controller_enable_r      <= RST_BYTE[BIT_EN];
      low_power_waveform_sel_r <= RST_BYTE[BIT_LP];
      frame_start_irq_enable_r <= RST_BYTE[BIT_IE];
      display_blank_r          <= RST_BYTE[BIT_BLANK];
    end else if (wr_ctrl) begin
      controller_enable_r      <= reg_wdata[BIT_EN];
      low_power_waveform_sel_r <= reg_wdata[BIT_LP];
      frame_start_irq_enable_r <= reg_wdata[BIT_IE];
      display_blank_r          <= reg_wdata[BIT_BLANK];
    end
  end

  // small variant keeps mask bit 3 at zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= sdc_cfg_type'(RST_BYTE);
      frr_r <= sdc_frr_type'(RST_BYTE);
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CFG) begin
        cfg_r <= sdc_cfg_type'(reg_wdata);
        cfg_r.segment_port_mask[3] <= reg_wdata[3] && !SMALL_VARIANT;
      end
      if (reg_addr == ADDR_FRR) begin
        frr_r       <= sdc_frr_type'(reg_wdata);
        frr_r.rsvd7 <= 1'b0;
        frr_r.rsvd3 <= 1'b0;
      end
    end
  end

  // set wins over write-one clear and vector acknowledge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_start_flag_r <= RST_BYTE[BIT_FLAG];
    end else if (flag_set) begin
      frame_start_flag_r <= 1'b1;
    end else if (irq_ack || (wr_ctrl && reg_wdata[BIT_FLAG])) begin
      frame_start_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= {controller_enable_r, low_power_waveform_sel_r, 1'b0,
                                 frame_start_flag_r, frame_start_irq_enable_r, 2'b00,
                                 display_blank_r};
        ADDR_CFG:  reg_rdata <= cfg_r;
        ADDR_FRR:  reg_rdata <= frr_r;
        default:   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // asynchronous display clock source, two-flop synchronised
  logic async_src;
  logic async_s1_r;
  logic async_s2_r;
  logic async_s3_r;
  logic disp_tick;

  // timer oscillator or external clock, per enable setting
  assign async_src = external_clock_input_enable ? ext_clock_pin : timer_osc_input_pin;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      async_s1_r <= 1'b0;
      async_s2_r <= 1'b0;
      async_s3_r <= 1'b0;
    end else begin
      async_s1_r <= async_src;
      async_s2_r <= async_s1_r;
      async_s3_r <= async_s2_r;
    end
  end

  // system clock ticks every cycle, async source on its rising edge
  assign disp_tick = cfg_r.async_clock_select ? (async_s2_r && !async_s3_r) : 1'b1;

  sdc_prescaler u_prescaler (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .run       (controller_enable_r),
    .disp_tick (disp_tick),
    .tap_sel   (frr_r.prescaler_tap_select),
    .divide    (frr_r.frame_clock_divide),
    .ps_tick   (ps_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame length follows duty
  assign k_last    = (cfg_r.duty_select == DUTY_THIRD) ? K_THIRD : K_OTHER;
  assign frame_end = controller_enable_r && ps_tick && (step_r >= k_last);
  // low-power waveform flags only even frames
  assign flag_set  = frame_end && (!lp_act_r || lp_phase_r);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_r <= 3'h0;
    end else if (!controller_enable_r) begin
      step_r <= 3'h0;
    end else if (ps_tick) begin
      step_r <= frame_end ? 3'h0 : step_r + 3'h1;
    end
  end

  // working copies load only at frame boundaries while running
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lp_act_r    <= 1'b0;
      blank_act_r <= 1'b0;
      lp_phase_r  <= 1'b0;
    end else if (!controller_enable_r) begin
      lp_act_r    <= low_power_waveform_sel_r;
      blank_act_r <= 1'b0;
      lp_phase_r  <= 1'b0;
    end else if (frame_end) begin
      // sample waveform and blanking just before the next frame
      lp_act_r    <= low_power_waveform_sel_r;
      // blanking starts only after the running frame completes
      blank_act_r <= display_blank_r;
      lp_phase_r  <= !lp_phase_r;
    end
  end

  // latch pulse and flag share the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_latch     <= 1'b0;
      frame_step_tick <= 1'b0;
      frame_step      <= 3'h0;
    end else begin
      frame_latch     <= flag_set;
      frame_step_tick <= controller_enable_r && ps_tick;
      frame_step      <= step_r;
    end
  end

  // request gated by flag, local and global enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_irq <= 1'b0;
    end else begin
      frame_irq <= frame_start_flag_r && frame_start_irq_enable_r && global_irq_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bias_mode        <= BIAS_STATIC;
      drive_ground     <= 1'b0;
      low_power_active <= 1'b0;
    end else begin
      if (cfg_r.duty_select == DUTY_STATIC) begin
        bias_mode <= BIAS_STATIC;
      end else if (cfg_r.half_bias_select) begin
        bias_mode <= BIAS_HALF;
      end else begin
        bias_mode <= BIAS_THIRD;
      end
      // all terminals to ground while blanking holds
      drive_ground     <= controller_enable_r && blank_act_r;
      low_power_active <= controller_enable_r && lp_act_r;
    end
  end

  // ownership drops with enable, pins fall back to port
  sdc_seg_mask u_seg_mask (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .enable    (controller_enable_r),
    .duty      (cfg_r.duty_select),
    .mask_code (cfg_r.segment_port_mask),
    .com_own   (com_drive_en),
    .seg_own   (seg_drive_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // cadence bookkeeping for the low-power check; cleared while stopped
  logic lp_prev_end_r;
  logic lp_prev_flag_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lp_prev_end_r  <= 1'b0;
      lp_prev_flag_r <= 1'b0;
    end else if (!controller_enable_r) begin
      lp_prev_end_r  <= 1'b0;
      lp_prev_flag_r <= 1'b0;
    end else if (frame_end) begin
      lp_prev_end_r  <= lp_act_r;
      lp_prev_flag_r <= flag_set;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_flag_clear_write;
    wr_ctrl && reg_wdata[BIT_FLAG] && !flag_set;
  endsequence

  sequence s_ctrl_read;
    reg_rd && reg_addr == ADDR_CTRL;
  endsequence

  chk_stop_immediate: assert property (
    $fell(controller_enable_r) |=> com_drive_en == '0 && seg_drive_en == '0 && !drive_ground)
    else $error("terminals still owned after disable");

  chk_flag_latch_pair: assert property (
    flag_set |=> frame_start_flag_r && frame_latch)
    else $error("flag and latch pulse not together");

  chk_irq_gate: assert property (
    frame_irq |-> $past(frame_start_flag_r && frame_start_irq_enable_r && global_irq_enable))
    else $error("interrupt without all enables");

  chk_flag_w1c: assert property (
    s_flag_clear_write |=> !frame_start_flag_r)
    else $error("write one did not clear flag");

  // only judged once two low-power frames follow each other, the switch frame may repeat
  chk_lp_alternate: assert property (
    (frame_end && lp_act_r && lp_prev_end_r) |-> flag_set != lp_prev_flag_r)
    else $error("low-power flag cadence broken");

  chk_blank_boundary: assert property (
    $rose(blank_act_r) |-> $past(frame_end))
    else $error("blanking began mid-frame");

  chk_rsvd_zero: assert property (
    s_ctrl_read |=> reg_rdata[2:1] == 2'b00 && !reg_rdata[5])
    else $error("reserved control bits read nonzero");

  chk_duty_commons: assert property (
    (controller_enable_r && $stable(cfg_r.duty_select)) |=>
      com_drive_en[3] == ($past(cfg_r.duty_select) == 2'h3))
    else $error("common ownership disagrees with duty");

  chk_idle_disabled: assert property (
    !controller_enable_r |=> !frame_latch && step_r == 3'h0)
    else $error("sequencer ran while disabled");

  chk_wave_boundary: assert property (
    (controller_enable_r && $changed(lp_act_r)) |-> $past(frame_end))
    else $error("waveform changed mid-frame");
endmodule

// ---- test/sdc_glass_model.sv ----
// clock sources and charge state of the display glass beside the controller
`timescale 1ns/1ps
module sdc_glass_model
  import sdc_pkg::*;
#(
  parameter int OSC_HALF_NS = 250,
  parameter int EXT_HALF_NS = 200
)(
  output logic                 osc_pin,
  output logic                 ext_pin,
  input  wire logic [NUM_COM-1:0] com_drive_en,
  input  wire logic            drive_ground,
  output logic                 glass_charged
);
  // crystal and external source run free, phase unrelated to clk_sys
  initial begin
    osc_pin = 1'b0;
    forever #(OSC_HALF_NS) osc_pin = ~osc_pin;
  end
  initial begin
    ext_pin = 1'b0;
    #37;
    forever #(EXT_HALF_NS) ext_pin = ~ext_pin;
  end
  // glass holds charge while any common is driven and not grounded
  assign glass_charged = (|com_drive_en) & ~drive_ground;
endmodule

// ---- test/segment_display_controller_ctrl_tb.sv ----
// self-checking bench for the segment display controller
`timescale 1ns/1ps
module segment_display_controller_ctrl_tb
  import sdc_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              gie = 1'b1;
  logic              irq_ack = 1'b0;
  logic              ext_en = 1'b0;
  logic [7:0]        reg_rdata;
  logic              osc_pin, ext_pin, glass_charged;
  logic              frame_irq, frame_latch, frame_step_tick, drive_ground, low_power_active;
  logic [2:0]        frame_step;
  sdc_bias_type      bias_mode;
  logic [NUM_COM-1:0] com_drive_en;
  logic [NUM_SEG-1:0] seg_drive_en;
  logic [7:0]        small_rdata;
  logic [NUM_SEG-1:0] small_seg;
  logic [7:0]        exp_q [$];
  logic              rd_pend = 1'b0;
  logic [31:0]       seed = 32'd47208;
  int                failures = 0;
  int                check_count = 0;
  localparam logic [7:0] T_CFG [6] = '{8'h30, 8'h20, 8'h00, 8'h10, 8'hB0, 8'hB0};
  localparam logic [7:0] T_FRR [6] = '{8'h00, 8'h01, 8'h10, 8'h00, 8'h00, 8'h00};
  localparam int T_PER [6] = '{128, 192, 512, 128, 1280, 1024};

  always #25 clk_sys = ~clk_sys;

  sdc_ctrl #(.SMALL_VARIANT(1'b0)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_enable(gie),
    .irq_ack(irq_ack), .external_clock_input_enable(ext_en),
    .timer_osc_input_pin(osc_pin), .ext_clock_pin(ext_pin), .frame_irq(frame_irq),
    .frame_latch(frame_latch), .frame_step_tick(frame_step_tick), .frame_step(frame_step),
    .drive_ground(drive_ground), .low_power_active(low_power_active),
    .bias_mode(bias_mode), .com_drive_en(com_drive_en), .seg_drive_en(seg_drive_en));

  sdc_glass_model glass (
    .osc_pin(osc_pin), .ext_pin(ext_pin), .com_drive_en(com_drive_en),
    .drive_ground(drive_ground), .glass_charged(glass_charged));

  // smaller variant shares the bus; only its read-back and segment ownership are watched
  sdc_ctrl #(.SMALL_VARIANT(1'b1)) uut_small (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(small_rdata), .global_irq_enable(gie),
    .irq_ack(irq_ack), .external_clock_input_enable(ext_en),
    .timer_osc_input_pin(osc_pin), .ext_clock_pin(ext_pin), .frame_irq(),
    .frame_latch(), .frame_step_tick(), .frame_step(), .drive_ground(),
    .low_power_active(), .bias_mode(), .com_drive_en(), .seg_drive_en(small_seg));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // whole values only, never read-modify-write of the flag register
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task automatic wait_latch(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (frame_latch !== 1'b1 && n < 5000);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_pend) check(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int cnt;
    logic [7:0] v;
    logic [31:0] rnd;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    wr(ADDR_FRR, 8'hFF);
    rd(ADDR_FRR, 8'h77);
    wr(ADDR_CTRL, 8'h26);
    rd(ADDR_CTRL, 8'h00);
    rd(2'h3, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    for (int i = 0; i < 6; i++) begin
      rnd = xs();
      v = {1'b0, rnd[6:0]};
      wr(ADDR_CFG, v);
      rd(ADDR_CFG, v);
      repeat (3) @(posedge clk_sys);
      check(com_drive_en, 4'hF >> (2'h3 - v[5:4]));
      check(seg_drive_en, {NUM_SEG{1'b1}} >> (6'd40 - SEG_COUNT[v[3:0]]));
      check(bias_mode, (v[5:4] == DUTY_STATIC) ? BIAS_STATIC :
                       (v[6] ? BIAS_HALF : BIAS_THIRD));
    end
    // small variant drops port mask bit 3, full build keeps all 40
    wr(ADDR_CFG, 8'h0F);
    rd(ADDR_CFG, 8'h0F);
    @(negedge clk_sys);
    check(small_rdata, 8'h07);
    check(small_seg, {NUM_SEG{1'b1}} >> (6'd40 - SEG_COUNT[7]));
    check(seg_drive_en, {NUM_SEG{1'b1}} >> (6'd40 - SEG_COUNT[15]));
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clk_sys);
    check(com_drive_en, 4'h0);
    check(seg_drive_en, '0);
    // frame period per setting and clock source
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CFG, T_CFG[i]);
      wr(ADDR_FRR, T_FRR[i]);
      ext_en <= (i == 5);
      wr(ADDR_CTRL, 8'h80);
      wait_latch(n);
      wait_latch(n);
      check(n, T_PER[i]);
      wr(ADDR_CTRL, 8'h00);
    end
    cnt = 0;
    repeat (600) begin
      @(posedge clk_sys);
      if (frame_latch === 1'b1 || frame_step_tick === 1'b1) cnt++;
    end
    check(cnt, 0);
    check(frame_step, 3'h0);
    ext_en <= 1'b0;
    wr(ADDR_CFG, 8'h30);
    wr(ADDR_CTRL, 8'h88);
    wait_latch(n);
    rd(ADDR_CTRL, 8'h98);
    check(frame_irq, 1'b1);
    gie <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(frame_irq, 1'b0);
    gie <= 1'b1;
    wr(ADDR_CTRL, 8'h88);
    rd(ADDR_CTRL, 8'h98);
    wr(ADDR_CTRL, 8'h98);
    rd(ADDR_CTRL, 8'h88);
    wait_latch(n);
    irq_ack <= 1'b1;
    @(posedge clk_sys);
    irq_ack <= 1'b0;
    rd(ADDR_CTRL, 8'h88);
    // low-power waveform from next frame, flag every second frame
    wait_latch(n);
    wr(ADDR_CTRL, 8'hD8);
    check(low_power_active, 1'b0);
    wait_latch(n);
    wait_latch(n);
    check(n, 256);
    check(low_power_active, 1'b1);
    // blank after the frame ends, then disable
    wr(ADDR_CTRL, 8'h91);
    check(drive_ground, 1'b0);
    wait_latch(n);
    repeat (2) @(posedge clk_sys);
    check(drive_ground, 1'b1);
    check(glass_charged, 1'b0);
    // disable releases every common, so com_drive_en reads zero afterwards
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clk_sys);
    check(com_drive_en, 4'h0);
    repeat (2) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule
